/* design/icfs_top.sv */
/*
 * dac datapath control: port a/b fifos with fill and pointer status, serial
 * register port, pre-modulation, three 2x stages, inverse sinc correction.
 * assumes fifo writes come from the data receiver on mclk; the serial port
 * pins are asynchronous and slow against mclk (sclk period 400 ns or more).
 */
// What this block does
// R1 - each port's fifo fill reads as an 8-bit thermometer code
// R2 - warning bit 7 set while port b pointers are within one
// R3 - warning bit 6 set while port b pointers are within two
// R4 - bit 5 reports port b pointers aligned after chip reset
// R5 - software requests realign with bit 3; device acknowledges in bit 4
// R6 - realigned pointers sit offset from optimal phase by 3-bit field
// R7 - pre-modulation bit rotates samples by half rate before stage one
// R8 - inverse sinc bypass bit, set after reset, skips the correction
// R9 - stage one doubles rate, 2-bit mode picks dc or half-rate shift
// R10 - stage one bypass bit skips stage one, clear after reset
// R11 - stage two doubles rate, 3-bit mode picks dc to three-quarter shift
// R12 - stage two bypass bit skips stage two, clear after reset
// R13 - stage three doubles rate, mode in bits 3:1 as stage two
// R14 - stage three bypass bit skips stage three, set after reset
// R15 - phase compensation bypass bit 7 of stage three register, set after reset
// R16 - bypassed stage passes samples unchanged; rate factor is two per active stage
// R17 - read-only identification register ignores writes
`timescale 1ns/1ps
`default_nettype none
module icfs_top
    import icfs_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
    parameter int DEPTH_LOG2 = 3
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic spi_csb_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic port_a_wr,
    input wire logic [15:0] port_a_data,
    input wire logic port_b_wr,
    input wire logic [15:0] port_b_data,
    output icfs_smp_s dac_smp,
    output logic phase_comp_on
);
    localparam int DEPTH = 2 ** DEPTH_LOG2;
    typedef logic [DEPTH_LOG2-1:0] icfs_ptr_t;
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] csb_s;
        logic [1:0] sdi_s;
        icfs_spi_e spi;
        logic [4:0] bits;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic rd;
        logic [6:0] addr;
        logic [7:0] ctrl_b;
        logic rst_aln;
        logic ack;
        logic [7:0] stg1;
        logic [7:0] stg2;
        logic [7:0] stg3;
        icfs_ptr_t wp_a;
        icfs_ptr_t rp_a;
        icfs_ptr_t wp_b;
        icfs_ptr_t rp_b;
        logic [2:0] rate;
        logic pm_odd;
        icfs_smp_s feed;
        icfs_smp_s prev;
        icfs_smp_s dac;
    } icfs_st_s;
    icfs_st_s st_reg;
    icfs_st_s st_next;
    logic [15:0] mem_a [DEPTH];
    logic [15:0] mem_b [DEPTH];
    icfs_smp_s s1_out;
    icfs_smp_s s2_out;
    icfs_smp_s s3_out;
    icfs_ptr_t cnt_a;
    icfs_ptr_t cnt_b;
    logic [7:0] fill_a;
    logic [7:0] fill_b;
    logic warn1;
    logic warn2;
    logic act1;
    logic act2;
    logic act3;
    logic [1:0] n_act;
    logic [1:0] lvl1;
    logic [1:0] lvl2;
    logic pop;
    logic sclk_rise;
    logic sclk_fall;
    logic spi_wr;
    logic [7:0] rdata;

    function automatic logic at_level(input logic [2:0] rate, input logic [1:0] lvl);
        logic [2:0] mask;
        mask = 3'((4'h1 << lvl) - 4'h1);
        return (rate & mask) == 3'h0;
    endfunction : at_level

    function automatic logic [7:0] therm(input icfs_ptr_t cnt);
        return 8'((9'h001 << cnt) - 9'h001);
    endfunction : therm

    // ****************************************
    // fifo status
    // ****************************************
    assign cnt_a = st_reg.wp_a - st_reg.rp_a;
    assign cnt_b = st_reg.wp_b - st_reg.rp_b;
    assign fill_a = therm(cnt_a); // [R1]
    assign fill_b = therm(cnt_b); // [R1]
    // distance is circular: near-empty and near-full both count as close
    assign warn1 = cnt_b <= icfs_ptr_t'(1) || cnt_b >= icfs_ptr_t'(DEPTH - 1); // [R2]
    assign warn2 = cnt_b <= icfs_ptr_t'(2) || cnt_b >= icfs_ptr_t'(DEPTH - 2); // [R3]

    // ****************************************
    // rate plan
    // ****************************************
    assign act1 = !st_reg.stg1[B_BYP]; // [R10]
    assign act2 = !st_reg.stg2[B_BYP]; // [R12]
    assign act3 = !st_reg.stg3[B_BYP]; // [R14]
    assign n_act = 2'(act1) + 2'(act2) + 2'(act3); // [R16]
    assign lvl1 = n_act - 2'(act1);
    assign lvl2 = lvl1 - 2'(act2);
    // one pop per 2^n_act cycles, final stage emits every cycle
    assign pop = at_level(st_reg.rate, n_act); // [R16]

    // ****************************************
    // serial register port
    // ****************************************
    assign sclk_rise = st_reg.sclk_s[1] && !st_reg.sclk_s[2];
    assign sclk_fall = !st_reg.sclk_s[1] && st_reg.sclk_s[2];
    assign spi_wr = st_reg.spi == ICFS_DATA && sclk_rise && !st_reg.rd
        && st_reg.bits == SPI_FRAME_BITS - 5'h01;
    always_comb begin
        unique case (st_reg.sh_in[6:0])
            ADDR_FILL_A: rdata = fill_a;
            ADDR_CTRL_B: rdata = {warn1, warn2, st_reg.rst_aln, st_reg.ack,
                st_reg.ctrl_b[3:0]};
            ADDR_FILL_B: rdata = fill_b;
            ADDR_STG1: rdata = st_reg.stg1;
            ADDR_STG2: rdata = st_reg.stg2;
            ADDR_STG3: rdata = st_reg.stg3;
            ADDR_ID: rdata = PART_ID; // [R17]
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.sclk_s = {st_reg.sclk_s[1:0], spi_sclk};
        st_next.csb_s = {st_reg.csb_s[0], spi_csb_n};
        st_next.sdi_s = {st_reg.sdi_s[0], spi_sdi};
        if (st_reg.csb_s[1]) begin
            st_next.spi = ICFS_IDLE;
        end else begin
            unique case (st_reg.spi)
                ICFS_IDLE: begin
                    st_next.spi = ICFS_HDR;
                    st_next.bits = 5'h00;
                end
                ICFS_HDR: if (sclk_rise) begin
                    st_next.sh_in = {st_reg.sh_in[6:0], st_reg.sdi_s[1]};
                    st_next.bits = st_reg.bits + 5'h01;
                    if (st_reg.bits == SPI_HDR_BITS - 5'h01) begin
                        st_next.spi = ICFS_DATA;
                        st_next.rd = st_reg.sh_in[6];
                        st_next.addr = st_reg.sh_in[6:0] & 7'h7F;
                    end
                end
                ICFS_DATA: begin
                    if (st_reg.bits == SPI_HDR_BITS && !sclk_rise) begin
                        st_next.addr = st_reg.sh_in[6:0];
                    end
                    if (sclk_fall && st_reg.bits > SPI_HDR_BITS) begin
                        st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        st_next.sh_in = {st_reg.sh_in[6:0], st_reg.sdi_s[1]};
                        st_next.bits = st_reg.bits + 5'h01;
                        if (st_reg.bits == SPI_FRAME_BITS - 5'h01) begin
                            st_next.spi = ICFS_DONE;
                        end
                    end
                end
                ICFS_DONE: st_next.spi = ICFS_DONE;
            endcase
        end
        // read data is cleared the cycle the header completes, then fetched each cycle without an sclk edge until the next rising sclk edge
        if (st_reg.spi == ICFS_HDR && st_next.spi == ICFS_DATA) begin
            st_next.sh_out = 8'h00;
        end
        if (st_reg.spi == ICFS_DATA && st_reg.bits == SPI_HDR_BITS && !sclk_fall
            && !sclk_rise) begin
            st_next.sh_out = rdata;
        end
        if (spi_wr) begin
            unique case (st_reg.addr)
                ADDR_CTRL_B: begin
                    st_next.ctrl_b = {4'h0, st_reg.sh_in[2:0], st_reg.sdi_s[1]};
                    if (!st_reg.sh_in[2]) begin
                        st_next.ack = 1'b0;
                    end
                end
                ADDR_STG1: st_next.stg1 = {st_reg.sh_in[6:0], st_reg.sdi_s[1]};
                ADDR_STG2: st_next.stg2 = {st_reg.sh_in[6:0], st_reg.sdi_s[1]};
                ADDR_STG3: st_next.stg3 = {st_reg.sh_in[6:0], st_reg.sdi_s[1]};
                default: ; // read-only and unmapped writes dropped [R17]
            endcase
        end
        // ********** fifos **********
        if (port_a_wr && cnt_a != icfs_ptr_t'(DEPTH - 1)) begin
            st_next.wp_a = st_reg.wp_a + icfs_ptr_t'(1);
        end
        if (port_b_wr && cnt_b != icfs_ptr_t'(DEPTH - 1)) begin
            st_next.wp_b = st_reg.wp_b + icfs_ptr_t'(1);
        end
        st_next.rate = st_reg.rate + 3'h1;
        st_next.feed.valid = 1'b0;
        if (pop) begin
            st_next.pm_odd = !st_reg.pm_odd;
            st_next.feed = {1'b1, mem_a[st_reg.rp_a], mem_b[st_reg.rp_b]};
            if (st_reg.stg1[B_PREMOD] && st_reg.pm_odd) begin
                st_next.feed.i = -mem_a[st_reg.rp_a]; // [R7]
                st_next.feed.q = -mem_b[st_reg.rp_b]; // [R7]
            end
            if (cnt_a != icfs_ptr_t'(0)) begin
                st_next.rp_a = st_reg.rp_a + icfs_ptr_t'(1);
            end
            if (cnt_b != icfs_ptr_t'(0)) begin
                st_next.rp_b = st_reg.rp_b + icfs_ptr_t'(1);
            end
        end
        // alignment after reset, then on each software request
        if (!st_reg.rst_aln || (st_reg.ctrl_b[B_REQ] && !st_reg.ack)) begin
            st_next.rp_b = st_reg.wp_b - FIFO_OPT_FILL - st_reg.ctrl_b[2:0]; // [R6]
            st_next.rst_aln = 1'b1; // [R4]
            if (st_reg.rst_aln) begin
                st_next.ack = 1'b1; // [R5]
            end
        end
        if (!st_reg.rst_aln) begin
            st_next.rp_a = st_reg.wp_a - FIFO_OPT_FILL;
        end
        // ********** inverse sinc correction **********
        st_next.prev = s3_out.valid ? s3_out : st_reg.prev;
        st_next.dac = s3_out;
        if (!st_reg.stg1[B_SINC_BYP] && s3_out.valid) begin // [R8]
            // cheap high-frequency lift; wraps on full-scale steps
            st_next.dac.i = s3_out.i + ((s3_out.i - st_reg.prev.i) >>> 3);
            st_next.dac.q = s3_out.q + ((s3_out.q - st_reg.prev.q) >>> 3);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.sclk_s <= 3'h0;
            st_reg.csb_s <= 2'h3;
            st_reg.ctrl_b <= CTRL_B_RST;
            st_reg.stg1 <= STG1_RST; // [R8] [R10]
            st_reg.stg2 <= STG2_RST; // [R12]
            st_reg.stg3 <= STG3_RST; // [R14] [R15]
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (port_a_wr && cnt_a != icfs_ptr_t'(DEPTH - 1)) begin
            mem_a[st_reg.wp_a] <= port_a_data;
        end
        if (port_b_wr && cnt_b != icfs_ptr_t'(DEPTH - 1)) begin
            mem_b[st_reg.wp_b] <= port_b_data;
        end
    end

    // ****************************************
    // interpolation chain
    // ****************************************
    icfs_stage u_stage1 (
        .mclk(mclk),
        .rst(rst),
        .out_en(at_level(st_reg.rate, lvl1)),
        .bypass(!act1),
        .mode({st_reg.stg1[2], 1'b0, st_reg.stg1[B_MODE]}), // [R9]
        .smp_in(st_reg.feed),
        .smp_out(s1_out)
    );
    icfs_stage u_stage2 (
        .mclk(mclk),
        .rst(rst),
        .out_en(at_level(st_reg.rate, lvl2)),
        .bypass(!act2),
        .mode(st_reg.stg2[3:1]), // [R11]
        .smp_in(s1_out),
        .smp_out(s2_out)
    );
    icfs_stage u_stage3 (
        .mclk(mclk),
        .rst(rst),
        .out_en(1'b1),
        .bypass(!act3),
        .mode(st_reg.stg3[3:1]), // [R13]
        .smp_in(s2_out),
        .smp_out(s3_out)
    );

    assign dac_smp = st_reg.dac;
    assign phase_comp_on = !st_reg.stg3[B_PHASE_BYP]; // [R15]
    assign spi_sdo = st_reg.sh_out[7];
    assign spi_sdo_oe = st_reg.spi == ICFS_DATA && st_reg.rd && !st_reg.csb_s[1];

    // ****************************************
    // checks
    // ****************************************
    chk_fill_therm: assert property (@(posedge mclk) disable iff (rst) // [R1]
        ((9'(fill_b) + 9'h001) & 9'(fill_b)) == 9'h000
        && ((9'(fill_a) + 9'h001) & 9'(fill_a)) == 9'h000)
        else $error("fill level not a thermometer code");
    chk_warn_one: assert property (@(posedge mclk) disable iff (rst) // [R2]
        warn1 == (!fill_b[1] || fill_b[6]))
        else $error("warning one disagrees with fill level");
    chk_warn_two: assert property (@(posedge mclk) disable iff (rst) // [R3]
        (warn2 == (!fill_b[2] || fill_b[5])) && (!warn1 || warn2))
        else $error("warning two disagrees with fill level");
    chk_reset_align: assert property (@(posedge mclk) disable iff (rst) // [R4]
        !st_reg.rst_aln |=> st_reg.rst_aln && $stable(st_reg.ack))
        else $error("pointers not aligned after reset");
    chk_align_ack: assert property (@(posedge mclk) disable iff (rst) // [R5]
        st_reg.rst_aln && st_reg.ctrl_b[B_REQ] && !st_reg.ack && !spi_wr |=> st_reg.ack)
        else $error("realign request not acknowledged");
    chk_phase_ofs: assert property (@(posedge mclk) disable iff (rst) // [R6]
        $rose(st_reg.ack) && !$past(port_b_wr) && !$past(pop)
        |-> cnt_b == icfs_ptr_t'(FIFO_OPT_FILL + st_reg.ctrl_b[2:0]))
        else $error("realigned pointer distance wrong");
    chk_sinc_byp: assert property (@(posedge mclk) disable iff (rst) // [R8]
        st_reg.stg1[B_SINC_BYP] |=> dac_smp == $past(s3_out))
        else $error("bypassed correction altered samples");
    chk_pop_rate: assert property (@(posedge mclk) disable iff (rst) // [R16]
        pop && n_act == 2'h1 && !spi_wr ##1 !spi_wr |-> !pop ##1 pop)
        else $error("pop spacing wrong for one active stage");
    chk_id_read: assert property (@(posedge mclk) disable iff (rst) // [R17]
        spi_wr && st_reg.addr == ADDR_ID |=> $stable(st_reg.stg3) && $stable(st_reg.ctrl_b))
        else $error("write to identification changed state");
    cov_write: cover property (@(posedge mclk) disable iff (rst) spi_wr);
    cov_read: cover property (@(posedge mclk) disable iff (rst) $rose(spi_sdo_oe));
    cov_realign: cover property (@(posedge mclk) disable iff (rst) $rose(st_reg.ack));
    cov_all_stages: cover property (@(posedge mclk) disable iff (rst)
        n_act == 2'h3 && pop);
endmodule : icfs_top
`default_nettype wire

/* design/icfs_pkg.sv */
/*
 * constants and carrier types of the interpolation chain and fifo status block.
 * assumes one dac-side clock, mclk, at 20 MHz.
 */
package icfs_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0] ADDR_FILL_A = 7'h18;
    localparam logic [6:0] ADDR_CTRL_B = 7'h19;
    localparam logic [6:0] ADDR_FILL_B = 7'h1A;
    localparam logic [6:0] ADDR_STG1 = 7'h1C;
    localparam logic [6:0] ADDR_STG2 = 7'h1D;
    localparam logic [6:0] ADDR_STG3 = 7'h1E;
    localparam logic [6:0] ADDR_ID = 7'h1F;
    localparam int B_WARN1 = 7;
    localparam int B_WARN2 = 6;
    localparam int B_RST_ALN = 5;
    localparam int B_ACK = 4;
    localparam int B_REQ = 3;
    localparam int B_PREMOD = 7;
    localparam int B_SINC_BYP = 6;
    localparam int B_PHASE_BYP = 7;
    localparam int B_BYP = 0;
    localparam int B_MODE = 1;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] STG1_RST = 8'h40;
    localparam logic [7:0] STG2_RST = 8'h00;
    localparam logic [7:0] STG3_RST = 8'h81;
    // ****************************************
    // fifo and serial port
    // ****************************************
    localparam logic [2:0] FIFO_OPT_FILL = 3'h4;
    localparam logic [4:0] SPI_HDR_BITS = 5'h08;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    typedef enum logic [1:0] {
        ICFS_IDLE = 2'b00,
        ICFS_HDR = 2'b01,
        ICFS_DATA = 2'b11,
        ICFS_DONE = 2'b10
    } icfs_spi_e;
    typedef struct packed {
        logic valid;
        logic signed [15:0] i;
        logic signed [15:0] q;
    } icfs_smp_s;
endpackage : icfs_pkg

/* design/icfs_stage.sv */
/*
 * one 2x interpolation stage with complex output rotation, or a plain bypass.
 * assumes out_en pulses at twice the rate of in.valid while active.
 */
`timescale 1ns/1ps
`default_nettype none
module icfs_stage
    import icfs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic out_en,
    input wire logic bypass,
    input wire logic [2:0] mode,
    input wire icfs_smp_s smp_in,
    output icfs_smp_s smp_out
);
    typedef struct packed {
        icfs_smp_s hold;
        icfs_smp_s out;
        logic [1:0] rot;
    } icfs_stg_s;
    icfs_stg_s st_reg;
    icfs_stg_s st_next;
    logic [1:0] step;
    // mode[2:1] picks dc, quarter, half or three-quarter output rate
    assign step = mode[2:1];
    always_comb begin
        st_next = st_reg;
        st_next.out.valid = 1'b0;
        if (bypass) begin
            st_next.out = smp_in; // [R16]
        end else begin
            if (smp_in.valid) begin
                st_next.hold = smp_in;
            end
            if (out_en) begin
                // each held input goes out twice, rotated by e^(j*pi*rot/2)
                // dc mode ignores any rotation left over from an earlier mode
                unique case (step == 2'b00 ? 2'b00 : st_reg.rot)
                    2'b00: st_next.out = {1'b1, st_reg.hold.i, st_reg.hold.q};
                    2'b01: st_next.out = {1'b1, -st_reg.hold.q, st_reg.hold.i};
                    2'b10: st_next.out = {1'b1, -st_reg.hold.i, -st_reg.hold.q};
                    2'b11: st_next.out = {1'b1, st_reg.hold.q, -st_reg.hold.i};
                endcase
                st_next.rot = st_reg.rot + step; // [R9] [R11] [R13]
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign smp_out = st_reg.out;
    // ****************************************
    // checks
    // ****************************************
    chk_byp_pass: assert property (@(posedge mclk) disable iff (rst) // [R16]
        bypass |=> smp_out == $past(smp_in))
        else $error("bypassed stage altered its input");
    chk_dc_mode: assert property (@(posedge mclk) disable iff (rst) // [R11]
        !bypass && out_en && step == 2'b00 |=> smp_out.i == $past(st_reg.hold.i))
        else $error("dc mode output differs from held sample");
    chk_half_flip: assert property (@(posedge mclk) disable iff (rst) // [R9]
        !bypass && out_en && step == 2'b10 && st_reg.rot == 2'b10
        |=> smp_out.i == -$past(st_reg.hold.i))
        else $error("half rate mode did not alternate sign");
    cov_active: cover property (@(posedge mclk) disable iff (rst)
        !bypass && smp_in.valid ##1 out_en [*2]);
endmodule : icfs_stage
`default_nettype wire

/* dv/icfs_bb_src.sv */
/*
 * baseband sample source feeding the port a and port b fifo write pins.
 * assumes the block samples port writes on rising mclk; writes every cycle
 * while run is high so the fifos sit near full whenever at least one stage is active.
 */
`timescale 1ns/1ps
`default_nettype none
module icfs_bb_src
    import icfs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [15:0] val_a,
    input wire logic [15:0] val_b,
    output logic wr_a,
    output logic [15:0] data_a,
    output logic wr_b,
    output logic [15:0] data_b
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_a <= 1'b0;
            wr_b <= 1'b0;
            data_a <= 16'h0000;
            data_b <= 16'h0000;
        end else if (run) begin
            wr_a <= 1'b1;
            wr_b <= 1'b1;
            data_a <= val_a;
            data_b <= val_b;
        end else begin
            // idle bus toggles so stale data is never mistaken for a sample
            wr_a <= 1'b0;
            wr_b <= 1'b0;
            data_a <= ~data_a;
            data_b <= ~data_b;
        end
    end
endmodule : icfs_bb_src
`default_nettype wire

/* dv/tb_top.sv */
/*
 * self-checking bench for icfs_top: serial register frames, fifo status,
 * realign handshake and sample stream through the stages.
 * assumes mclk 50 ns, serial clock 500 ns, constant samples from the source.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import icfs_pkg::*;
    logic mclk, rst, spi_csb_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
    logic run, a_wr, b_wr, phase_comp_on;
    logic [15:0] a_d, b_d;
    icfs_smp_s dac_smp;
    int error_cnt, n_checks;

    icfs_top i_icfs_top (.mclk(mclk), .rst(rst), .spi_csb_n(spi_csb_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .port_a_wr(a_wr), .port_a_data(a_d),
        .port_b_wr(b_wr), .port_b_data(b_d), .dac_smp(dac_smp),
        .phase_comp_on(phase_comp_on));
    icfs_bb_src i_icfs_bb_src (.mclk(mclk), .rst(rst), .run(run), .val_a(16'h1234),
        .val_b(16'h0568), .wr_a(a_wr), .data_a(a_d), .wr_b(b_wr), .data_b(b_d));

    // ****************************************
    // helpers
    // ****************************************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task spi(input logic rd, input logic [6:0] ad, input logic [7:0] wd,
             output logic [7:0] rv);
        logic [15:0] fr;
        fr = {rd, ad, wd};
        rv = 8'h00;
        @(posedge mclk) spi_csb_n <= 1'b0;
        for (int k = 15; k >= 0; k--) begin
            @(posedge mclk);
            spi_sclk <= 1'b0;
            spi_sdi <= fr[k];
            repeat (4) @(posedge mclk);
            #1;
            if (k < 8) begin
                rv[k] = spi_sdo;
                check(spi_sdo_oe, rd);
            end
            @(posedge mclk) spi_sclk <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        @(posedge mclk);
        spi_sclk <= 1'b0;
        spi_csb_n <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask : spi

    task wr(input logic [6:0] ad, input logic [7:0] wd);
        logic [7:0] dummy;
        spi(1'b0, ad, wd, dummy);
    endtask : wr

    task rd_chk(input logic [6:0] ad, input logic [7:0] exp);
        logic [7:0] v;
        spi(1'b1, ad, 8'h00, v);
        check(v, exp);
    endtask : rd_chk

    // first sample sets the sign, then alt says whether each next one flips
    task chk_stream(input logic [15:0] ei, input logic [15:0] eq, input logic alt);
        logic [15:0] pi, nx, mq;
        repeat (20) @(posedge mclk);
        #1;
        pi = dac_smp.i;
        nx = pi[15] ? -pi : pi;
        mq = pi[15] ? -eq : eq;
        check(nx, ei);
        check(dac_smp.q, mq);
        repeat (8) begin
            @(posedge mclk);
            #1;
            nx = alt ? -pi : pi;
            check(dac_smp.valid, 1'b1);
            check(dac_smp.i, nx);
            pi = nx;
        end
    endtask : chk_stream

    task stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        logic [7:0] v;
        check(phase_comp_on, 1'b0);
        rd_chk(ADDR_STG1, 8'h40);
        rd_chk(ADDR_STG2, 8'h00);
        rd_chk(ADDR_STG3, 8'h81);
        wr(ADDR_ID, 8'h00);
        rd_chk(ADDR_ID, 8'h5A);
        rd_chk(7'h30, 8'h00);
        spi(1'b1, ADDR_CTRL_B, 8'h00, v);
        check(v[5:0], 6'h20);
    endtask : t_reset

    task t_full;
        logic [7:0] v;
        @(posedge mclk) run <= 1'b1;
        repeat (40) @(posedge mclk);
        // a pop may land just before capture, so fill 6 is accepted too
        spi(1'b1, ADDR_FILL_A, 8'h00, v);
        check(v | 8'h40, 8'h7F);
        spi(1'b1, ADDR_FILL_B, 8'h00, v);
        check(v | 8'h40, 8'h7F);
        spi(1'b1, ADDR_CTRL_B, 8'h00, v);
        check(v[6:5], 2'b11);
    endtask : t_full

    task t_empty;
        logic [7:0] v;
        @(posedge mclk) run <= 1'b0;
        wr(ADDR_STG1, 8'h41);
        wr(ADDR_STG2, 8'h01);
        rd_chk(ADDR_FILL_B, 8'h00);
        rd_chk(ADDR_FILL_A, 8'h00);
        spi(1'b1, ADDR_CTRL_B, 8'h00, v);
        check(v[7:6], 2'b11);
    endtask : t_empty

    task t_realign;
        logic [7:0] v;
        wr(ADDR_CTRL_B, 8'hFB);
        spi(1'b1, ADDR_CTRL_B, 8'h00, v);
        check(v[4:0], 5'h1B);
        wr(ADDR_CTRL_B, 8'h03);
        spi(1'b1, ADDR_CTRL_B, 8'h00, v);
        check(v[4:0], 5'h03);
    endtask : t_realign

    task t_modes;
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_STG2, {4'h0, m[2:0], 1'b1});
            wr(ADDR_STG3, {4'h8, m[2:0], 1'b1});
            rd_chk(ADDR_STG2, {4'h0, m[2:0], 1'b1});
            rd_chk(ADDR_STG3, {4'h8, m[2:0], 1'b1});
        end
        wr(ADDR_STG2, 8'h01);
        wr(ADDR_STG3, 8'h81);
    endtask : t_modes

    task t_stream;
        @(posedge mclk) run <= 1'b1;
        chk_stream(16'h1234, 16'h0568, 1'b0);
        wr(ADDR_STG1, 8'hC1);
        chk_stream(16'h1234, 16'h0568, 1'b1);
        wr(ADDR_STG1, 8'h81);
        chk_stream(16'h16C1, 16'h06C2, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_STG1, {5'h08, m[1:0], 1'b0});
            chk_stream(16'h1234, 16'h0568, m[1]);
        end
        wr(ADDR_STG1, 8'h41);
        wr(ADDR_STG2, 8'h00);
        chk_stream(16'h1234, 16'h0568, 1'b0);
        wr(ADDR_STG2, 8'h08);
        chk_stream(16'h1234, 16'h0568, 1'b1);
        wr(ADDR_STG2, 8'h01);
        wr(ADDR_STG3, 8'h08);
        check(phase_comp_on, 1'b1);
        chk_stream(16'h1234, 16'h0568, 1'b1);
        wr(ADDR_STG3, 8'h80);
        chk_stream(16'h1234, 16'h0568, 1'b0);
    endtask : t_stream

    // ****************************************
    // clock, reset, sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        #4ms;
        error_cnt++;
        stop_test();
    end

    initial begin
        error_cnt = 0;
        n_checks = 0;
        rst = 1'b1;
        spi_csb_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        run = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_full();
        t_empty();
        t_realign();
        t_modes();
        t_stream();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
